// ===== fwcp_cmd_port.v
// What this block does
// [R1] Slave node only; station address 1 to 511, default 1.
// [R2] Gross weight at 0x0004, net weight at 0x0008, four bytes each.
// [R3] Status at 0x0010, inputs 0x0012, outputs 0x0014; outputs in bits 0-2.
// [R4] Master puts command at 0x0004 and output drive at 0x0006.
// [R5] First four bytes each way belong to ring link management.
// [R6] Weights unsigned with implied decimals; sign and errors in status.
// [R7] Input one in bit 0, input two in bit 1; 1 means high.
// [R8] Drive bits 0-2 set remote-mode outputs; 1 closes, 0 opens.
// [R9] Drive bit 15 gives master every output regardless of mode.
// [R10] Status bits 0-6 carry the error and range flags in order.
// [R11] Status bits 7-12 carry sign, net, stable, zero; 13-14 unused.
// [R12] Status bit 15 toggles once per second while healthy.
// [R13] Decode codes 7,8,9,21,22,23 as immediate actions.
// [R14] Separate read exchange (tx 0x000C) and write exchange (rx 0x0008).
// [R15] Read codes load the requested value into the read exchange.
// [R16] Write codes store the write exchange value on the code.
// [R17] Master sends code 0 between two equal commands.
// [R18] Codes 100,101,104,106 need qualified access, else refused.
// [R19] 100 zero tare, 101 first sample, 106 add sample, 104 cancel.
// [R20] 120 submits identity, 121 submits password, both after 124.
// [R21] After successful password, seed read returns zero.
// [R22] Setpoints volatile; copied to non-volatile store only on code 99.
// [R23] Code 130 activates the preset tare written with 88.
// [R24] Act only when command changes to a nonzero code.
// [R25] Unassigned codes change nothing.
`timescale 1ns/10ps
`include "fwcp_defines.vh"

module fwcp_cmd_port #(
  parameter [`FWCP_HB_CNT_W-1:0] HB_CYCLES = `FWCP_HB_CYCLES
) (
  input  wire        sys_clk,         // System clock, 100 MHz
  input  wire        rst_n,           // Sync reset, active low
  input  wire [8:0]  cfg_station_addr,// Configured address
  input  wire        rx_valid,        // New master image this cycle
  input  wire [15:0] rx_command_code, // Command code word
  input  wire [15:0] rx_output_drive, // Output drive word
  input  wire [31:0] rx_xchg_write,   // Write exchange word
  input  wire [31:0] gross_mag,       // Gross weight magnitude
  input  wire [31:0] net_mag,         // Net weight magnitude
  input  wire [12:0] weigh_flags,     // Status flags, bits 0-12
  input  wire        core_healthy,    // Instrument running correctly
  input  wire [1:0]  input_pins,      // Digital inputs, 1 = high
  input  wire [2:0]  local_outs,      // Setpoint-driven output levels
  input  wire [2:0]  remote_controlled_output_mode, // Per output
  output reg  [8:0]  station_addr_q,  // Station address in use
  output reg  [31:0] tx_gross_q,      // Gross weight image word
  output reg  [31:0] tx_net_q,        // Net weight image word
  output reg  [31:0] tx_xchg_read_q,  // Read exchange image word
  output reg  [15:0] tx_status_q,     // Status image word
  output reg  [15:0] tx_in_state_q,   // Input state image word
  output reg  [15:0] tx_out_state_q,  // Output state image word
  output reg  [2:0]  out_close_q,     // Output contacts, 1 = closed
  output reg  [31:0] setpoint1_q,     // Setpoint 1, volatile
  output reg  [31:0] setpoint2_q,     // Setpoint 2, volatile
  output reg  [31:0] setpoint3_q,     // Setpoint 3, volatile
  output reg  [31:0] preset_tare_q,   // Preset tare value
  output reg  [31:0] sample_wt_q,     // Calibration sample weight
  output reg         qualified_q,     // Qualified access granted
  output reg         tare_on_q,       // Pulse: tare, show net
  output reg         zero_q,          // Pulse: semi-automatic zero
  output reg         tare_off_q,      // Pulse: tare off, show gross
  output reg         key_lock_q,      // Pulse: keypad lock
  output reg         all_unlock_q,    // Pulse: keypad+display unlock
  output reg         all_lock_q,      // Pulse: keypad+display lock
  output reg         nvm_save_q,      // Pulse: copy setpoints to NVM
  output reg         ptare_en_q,      // Pulse: activate preset tare
  output reg         cal_zero_q,      // Pulse: zero tare for calibration
  output reg         cal_first_q,     // Pulse: store first sample
  output reg         cal_add_q,       // Pulse: add a sample
  output reg         cal_cancel_q,    // Pulse: cancel real calibration
  output reg         refused_q        // Pulse: command needed access
);

  // ****
  // Access sequence states
  // ****
  localparam [2:0] ACC_IDLE    = 3'b001;
  localparam [2:0] ACC_ID_SENT = 3'b010;
  localparam [2:0] ACC_GRANTED = 3'b100;

  reg [2:0]  acc_q;
  reg [2:0]  acc_d;

  reg [15:0] cmd_last_q;

  reg [31:0] cred_q;
  reg [31:0] seed_q;
  reg [31:0] seed_d;

  reg        heart_q;

  wire       hb_tick;
  wire       cmd_new;

  // ****
  // Helper functions
  // ****

  // Codes that only run under qualified access
  function needs_access;
    input [15:0] code;
    begin
      needs_access = (code == `FWCP_C_CAL_ZERO)   ||
                     (code == `FWCP_C_CAL_FIRST)  ||
                     (code == `FWCP_C_CAL_CANCEL) ||
                     (code == `FWCP_C_CAL_ADD);
    end
  endfunction

  // Scramble used both for the seed and for the expected password
  function [31:0] scramble;
    input [31:0] v;
    begin
      scramble = {v[18:0], v[31:19]} ^ `FWCP_ACCESS_KEY;
    end
  endfunction

  // Output level: master forces all, else only remote-mode outputs
  function [2:0] drive_mux;
    input [15:0] drv;
    input [2:0]  mode;
    input [2:0]  loc;
    integer      i;

    begin
      drive_mux = 3'h0;
      for (i = 0; i < `FWCP_NUM_OUTS; i = i + 1) begin
        if (drv[`FWCP_DRV_FORCE_BIT] || mode[i])  // see [R9]
          drive_mux[i] = drv[i];                  // see [R8]
        else
          drive_mux[i] = loc[i];
      end
    end
  endfunction

  // ****
  // Heartbeat divider
  // ****
  // Counts only while the core reports healthy
  fwcp_heartbeat #(
    .PERIOD (HB_CYCLES)
  ) u_heartbeat (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .run     (core_healthy),
    .tick    (hb_tick)
  );

  // Toggle once per tick; a faulty core freezes the bit
  always @(posedge sys_clk) begin
    if (!rst_n)
      heart_q <= 1'b0;
    else if (hb_tick && core_healthy)
      heart_q <= ~heart_q;  // see [R12]
  end

  // ****
  // Station address
  // ****

  // Zero is not a legal slave address, fall back to the default
  always @(posedge sys_clk) begin
    if (!rst_n)
      station_addr_q <= `FWCP_ADDR_DEFAULT;
    else if (cfg_station_addr < `FWCP_ADDR_MIN)
      station_addr_q <= `FWCP_ADDR_DEFAULT;  // see [R1]
    else
      station_addr_q <= cfg_station_addr;    // see [R1]
  end

  // ****
  // Transmitted image words
  // ****

  // Link words at 0x0000-0x0003 are left to the ring controller, see [R5]
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      tx_gross_q     <= 32'h0000_0000;
      tx_net_q       <= 32'h0000_0000;
      tx_status_q    <= 16'h0000;
      tx_in_state_q  <= 16'h0000;
      tx_out_state_q <= 16'h0000;
      out_close_q    <= 3'h0;
    end else begin
      tx_gross_q  <= gross_mag;                      // see [R2] [R6]
      tx_net_q    <= net_mag;                        // see [R2] [R6]
      tx_status_q <= {heart_q, 2'b00, weigh_flags};  // see [R10] [R11]
      tx_in_state_q <= {14'h0000, input_pins};       // see [R7]
      out_close_q <= drive_mux(rx_output_drive,
                               remote_controlled_output_mode,
                               local_outs);
      tx_out_state_q <= {13'h0000, out_close_q};     // see [R3]
    end
  end

  // ****
  // Command change detection
  // ****

  // A repeated value is no request; the master must pass through 0
  assign cmd_new = rx_valid && (rx_command_code != cmd_last_q) &&
                   (rx_command_code != `FWCP_C_NONE);  // see [R24] [R17]

  // Last code taken, zero included, so 0 rearms a repeat
  always @(posedge sys_clk) begin
    if (!rst_n)
      cmd_last_q <= `FWCP_C_NONE;
    else if (rx_valid)
      cmd_last_q <= rx_command_code;  // see [R4] [R24]
  end

  // ****
  // Access sequence next state
  // ****
  always @* begin
    acc_d  = acc_q;
    seed_d = seed_q;
    if (cmd_new) begin
      case (acc_q)
        ACC_IDLE: begin
          if (rx_command_code == `FWCP_C_ID_SEND) begin
            acc_d  = ACC_ID_SENT;       // see [R20]
            seed_d = scramble(cred_q);
          end
        end
        ACC_ID_SENT: begin
          if (rx_command_code == `FWCP_C_PW_SEND) begin
            if (cred_q == scramble(seed_q)) begin
              acc_d  = ACC_GRANTED;     // see [R20]
              seed_d = 32'h0000_0000;   // see [R21]
            end else begin
              acc_d = ACC_IDLE;
            end
          end else if (rx_command_code == `FWCP_C_ID_SEND) begin
            seed_d = scramble(cred_q);
          end
        end
        ACC_GRANTED: begin
          acc_d = ACC_GRANTED;
        end
        default: begin
          acc_d  = ACC_IDLE;
          seed_d = 32'h0000_0000;
        end
      endcase
    end
  end

  // Access is lost only at reset, as at instrument power off
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      acc_q       <= ACC_IDLE;
      seed_q      <= 32'h0000_0000;
      qualified_q <= 1'b0;
    end else begin
      acc_q       <= acc_d;
      seed_q      <= seed_d;
      qualified_q <= (acc_d == ACC_GRANTED);
    end
  end

  // ****
  // Command execution
  // ****

  // Action pulses last one cycle; stores change only on their code
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      tx_xchg_read_q <= 32'h0000_0000;  // see [R14]
      setpoint1_q    <= 32'h0000_0000;
      setpoint2_q    <= 32'h0000_0000;
      setpoint3_q    <= 32'h0000_0000;
      preset_tare_q  <= 32'h0000_0000;
      sample_wt_q    <= 32'h0000_0000;
      cred_q         <= 32'h0000_0000;

      tare_on_q      <= 1'b0;
      zero_q         <= 1'b0;
      tare_off_q     <= 1'b0;
      key_lock_q     <= 1'b0;
      all_unlock_q   <= 1'b0;
      all_lock_q     <= 1'b0;
      nvm_save_q     <= 1'b0;
      ptare_en_q     <= 1'b0;
      cal_zero_q     <= 1'b0;
      cal_first_q    <= 1'b0;
      cal_add_q      <= 1'b0;
      cal_cancel_q   <= 1'b0;
      refused_q      <= 1'b0;
    end else begin
      tare_on_q    <= 1'b0;
      zero_q       <= 1'b0;
      tare_off_q   <= 1'b0;
      key_lock_q   <= 1'b0;
      all_unlock_q <= 1'b0;
      all_lock_q   <= 1'b0;
      nvm_save_q   <= 1'b0;
      ptare_en_q   <= 1'b0;
      cal_zero_q   <= 1'b0;
      cal_first_q  <= 1'b0;
      cal_add_q    <= 1'b0;
      cal_cancel_q <= 1'b0;
      refused_q    <= 1'b0;

      if (cmd_new && needs_access(rx_command_code) && !qualified_q) begin
        refused_q <= 1'b1;  // see [R18]
      end else if (cmd_new) begin
        case (rx_command_code)
          `FWCP_C_TARE_ON:    tare_on_q    <= 1'b1;  // see [R13]
          `FWCP_C_ZERO:       zero_q       <= 1'b1;  // see [R13]
          `FWCP_C_TARE_OFF:   tare_off_q   <= 1'b1;  // see [R13]
          `FWCP_C_KEY_LOCK:   key_lock_q   <= 1'b1;  // see [R13]
          `FWCP_C_ALL_UNLOCK: all_unlock_q <= 1'b1;  // see [R13]
          `FWCP_C_ALL_LOCK:   all_lock_q   <= 1'b1;  // see [R13]
          `FWCP_C_PTARE_RD:   tx_xchg_read_q <= preset_tare_q;  // see [R15]
          `FWCP_C_SP1_RD:     tx_xchg_read_q <= setpoint1_q;    // see [R15]
          `FWCP_C_SP2_RD:     tx_xchg_read_q <= setpoint2_q;    // see [R15]
          `FWCP_C_SP3_RD:     tx_xchg_read_q <= setpoint3_q;    // see [R15]
          `FWCP_C_SAMPLE_RD:  tx_xchg_read_q <= sample_wt_q;    // see [R15]
          `FWCP_C_SEED_RD:    tx_xchg_read_q <= seed_q;  // see [R15] [R21]
          `FWCP_C_CRED_RD:    tx_xchg_read_q <= cred_q;         // see [R15]
          `FWCP_C_PTARE_WR:   preset_tare_q <= rx_xchg_write;  // see [R16]
          `FWCP_C_SP1_WR:     setpoint1_q   <= rx_xchg_write;  // see [R16]
          `FWCP_C_SP2_WR:     setpoint2_q   <= rx_xchg_write;  // see [R16]
          `FWCP_C_SP3_WR:     setpoint3_q   <= rx_xchg_write;  // see [R16]
          `FWCP_C_SAMPLE_WR:  sample_wt_q   <= rx_xchg_write;  // see [R16]
          // Stored even before access: the access steps depend on it
          `FWCP_C_CRED_WR:    cred_q <= rx_xchg_write;  // see [R16] [R20]
          `FWCP_C_NVM_SAVE:   nvm_save_q   <= 1'b1;  // see [R22]
          `FWCP_C_PTARE_EN:   ptare_en_q   <= 1'b1;  // see [R23]
          `FWCP_C_CAL_ZERO:   cal_zero_q   <= 1'b1;  // see [R19]
          `FWCP_C_CAL_FIRST:  cal_first_q  <= 1'b1;  // see [R19]
          `FWCP_C_CAL_ADD:    cal_add_q    <= 1'b1;  // see [R19]
          `FWCP_C_CAL_CANCEL: cal_cancel_q <= 1'b1;  // see [R19]
          default: begin
            refused_q <= 1'b0;  // see [R25]
          end
        endcase
      end
    end
  end

endmodule

// ===== fwcp_cmd_port_properties.sv
`timescale 1ns/10ps
`include "fwcp_defines.vh"

// ****
// Port checker for the command port
// ****
module fwcp_cmd_checker #(
  parameter [`FWCP_HB_CNT_W-1:0] HB_CYCLES = `FWCP_HB_CYCLES
) (
  input wire        sys_clk,         // Clock
  input wire        rst_n,           // Sync reset
  input wire        rx_valid,        // Image strobe
  input wire [15:0] rx_command_code, // Command word
  input wire [15:0] rx_output_drive, // Drive word
  input wire [31:0] rx_xchg_write,   // Write exchange
  input wire [31:0] gross_mag,       // Gross magnitude
  input wire [12:0] weigh_flags,     // Status flags
  input wire        core_healthy,    // Alive source
  input wire [31:0] tx_gross_q,      // Gross image
  input wire [31:0] tx_xchg_read_q,  // Read exchange
  input wire [15:0] tx_status_q,     // Status image
  input wire [15:0] tx_out_state_q,  // Output image
  input wire [2:0]  out_close_q,     // Contacts
  input wire [31:0] setpoint1_q,     // Setpoint 1
  input wire        qualified_q,     // Access granted
  input wire        tare_on_q,       // Tare pulse
  input wire        cal_zero_q,      // Cal zero pulse
  input wire        refused_q        // Refusal pulse
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  reg [15:0]               last_q;
  reg                      hb_q;
  reg [`FWCP_HB_CNT_W:0]   hb_cnt_q;
  wire                     new_cmd;

  // Command history, mirrors the edge detection of the port
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      last_q <= 16'h0000;
    end else if (rx_valid) begin
      last_q <= rx_command_code;
    end
  end
  assign new_cmd = rx_valid && rx_command_code != 16'h0000 &&
                   rx_command_code != last_q;

  // Cycles since the alive bit last moved; cleared while unhealthy
  always @(posedge sys_clk) begin
    hb_q <= tx_status_q[15];
    if (!rst_n || !core_healthy || tx_status_q[15] != hb_q) begin
      hb_cnt_q <= 0;
    end else begin
      hb_cnt_q <= hb_cnt_q + 1'b1;
    end
  end

  sequence s_new(logic [15:0] c);
    new_cmd && rx_command_code == c;
  endsequence

  a_tare_pulse: assert property (s_new(16'h0007) |=> tare_on_q)
    else $error("tare code gave no pulse");
  a_repeat_quiet: assert property (
    rx_valid && rx_command_code == last_q
    |=> !tare_on_q && !refused_q) else $error("repeated code acted");
  a_sp1_store: assert property (s_new(16'h005D)
    |=> setpoint1_q == $past(rx_xchg_write)) else $error("setpoint store");
  a_sp1_fetch: assert property (s_new(16'h005A)
    |=> tx_xchg_read_q == $past(setpoint1_q)) else $error("setpoint fetch");
  a_locked_refuse: assert property (s_new(16'h0064)
    ##0 !qualified_q |=> refused_q && !cal_zero_q)
    else $error("locked code not refused");
  a_force_drive: assert property (rx_output_drive[15]
    |=> out_close_q == $past(rx_output_drive[2:0])) else $error("force");
  a_out_mirror: assert property ($past(rst_n)
    |-> tx_out_state_q == {13'h0000, $past(out_close_q)})
    else $error("output state image");
  a_copy_path: assert property ($past(rst_n)
    |-> tx_gross_q == $past(gross_mag) &&
    tx_status_q[14:0] == {2'h0, $past(weigh_flags)})
    else $error("gross or status copy");
  a_seed_cleared: assert property (qualified_q ##0 s_new(16'h007A)
    |=> tx_xchg_read_q == 32'h00000000) else $error("seed not zero");
  a_heart_alive: assert property (hb_cnt_q <= HB_CYCLES + 2)
    else $error("alive bit stalled");
endmodule

bind fwcp_cmd_port fwcp_cmd_checker #(.HB_CYCLES(HB_CYCLES)) fwcp_cmd_checker_i (
  .sys_clk(sys_clk), .rst_n(rst_n), .rx_valid(rx_valid),
  .rx_command_code(rx_command_code), .rx_output_drive(rx_output_drive),
  .rx_xchg_write(rx_xchg_write), .gross_mag(gross_mag),
  .weigh_flags(weigh_flags), .core_healthy(core_healthy),
  .tx_gross_q(tx_gross_q), .tx_xchg_read_q(tx_xchg_read_q),
  .tx_status_q(tx_status_q), .tx_out_state_q(tx_out_state_q),
  .out_close_q(out_close_q), .setpoint1_q(setpoint1_q),
  .qualified_q(qualified_q), .tare_on_q(tare_on_q),
  .cal_zero_q(cal_zero_q), .refused_q(refused_q));

// ===== fwcp_cmd_port_tb_top.sv
`timescale 1ns/10ps
`include "fwcp_defines.vh"
`define FWCP_CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin \
  failures++; $display("MISMATCH t=%0t got %h exp %h", $time, got, exp); end end

module fwcp_cmd_port_tb_top;
  reg sys_clk = 0, rst_n = 0, core_healthy = 1;
  reg [8:0] cfg_station_addr = 0;
  reg [31:0] gross_mag = 0, net_mag = 0, seed;
  reg [12:0] weigh_flags = 0;
  reg [1:0] input_pins = 0;
  reg [2:0] local_outs = 0, remote_controlled_output_mode = 0;
  wire rx_valid, qualified_q, refused_q, tare_on_q, zero_q, tare_off_q;
  wire key_lock_q, all_unlock_q, all_lock_q, nvm_save_q, ptare_en_q;
  wire cal_zero_q, cal_first_q, cal_add_q, cal_cancel_q;
  wire [15:0] rx_command_code, rx_output_drive;
  wire [15:0] tx_status_q, tx_in_state_q, tx_out_state_q;
  wire [31:0] rx_xchg_write, tx_gross_q, tx_net_q, tx_xchg_read_q;
  wire [31:0] setpoint1_q, setpoint2_q, setpoint3_q, preset_tare_q, sample_wt_q;
  wire [8:0] station_addr_q;
  wire [2:0] out_close_q;
  wire [7:0] imm = {ptare_en_q, nvm_save_q, all_lock_q, all_unlock_q,
                    key_lock_q, tare_off_q, zero_q, tare_on_q};
  wire [3:0] cal = {cal_add_q, cal_cancel_q, cal_first_q, cal_zero_q};
  int failures = 0, num_checks = 0, cycles = 0, i, tg;
  reg [15:0] imm_c [8] = '{16'h0007, 16'h0008, 16'h0009, 16'h0015,
                           16'h0016, 16'h0017, 16'h0063, 16'h0082};
  reg [15:0] wr_c [5] = '{16'h0058, 16'h005D, 16'h005E, 16'h005F, 16'h0067};
  reg [15:0] rd_c [5] = '{16'h0057, 16'h005A, 16'h005B, 16'h005C, 16'h0066};
  reg [15:0] gate_c [4] = '{16'h0064, 16'h0065, 16'h0068, 16'h006A};
  reg [31:0] val [5] = '{32'h0000_1F40, 32'h0001_86A0, 32'h0000_0001,
                         32'h7FFF_FFFF, 32'hFFFF_FFC8};

  always #5 sys_clk = ~sys_clk;

  fwcp_master_model fwcp_master_model_i (.sys_clk(sys_clk),
    .rx_valid(rx_valid), .rx_command_code(rx_command_code),
    .rx_output_drive(rx_output_drive), .rx_xchg_write(rx_xchg_write));

  fwcp_cmd_port #(.HB_CYCLES(20)) fwcp_cmd_port_i (.sys_clk(sys_clk),
    .rst_n(rst_n), .cfg_station_addr(cfg_station_addr), .rx_valid(rx_valid),
    .rx_command_code(rx_command_code), .rx_output_drive(rx_output_drive),
    .rx_xchg_write(rx_xchg_write), .gross_mag(gross_mag), .net_mag(net_mag),
    .weigh_flags(weigh_flags), .core_healthy(core_healthy),
    .input_pins(input_pins), .local_outs(local_outs),
    .remote_controlled_output_mode(remote_controlled_output_mode),
    .station_addr_q(station_addr_q), .tx_gross_q(tx_gross_q),
    .tx_net_q(tx_net_q), .tx_xchg_read_q(tx_xchg_read_q),
    .tx_status_q(tx_status_q), .tx_in_state_q(tx_in_state_q),
    .tx_out_state_q(tx_out_state_q), .out_close_q(out_close_q),
    .setpoint1_q(setpoint1_q), .setpoint2_q(setpoint2_q),
    .setpoint3_q(setpoint3_q), .preset_tare_q(preset_tare_q),
    .sample_wt_q(sample_wt_q), .qualified_q(qualified_q),
    .tare_on_q(tare_on_q), .zero_q(zero_q), .tare_off_q(tare_off_q),
    .key_lock_q(key_lock_q), .all_unlock_q(all_unlock_q),
    .all_lock_q(all_lock_q), .nvm_save_q(nvm_save_q),
    .ptare_en_q(ptare_en_q), .cal_zero_q(cal_zero_q),
    .cal_first_q(cal_first_q), .cal_add_q(cal_add_q),
    .cal_cancel_q(cal_cancel_q), .refused_q(refused_q));

  // Own copy of the access scramble, kept apart from the design
  function [31:0] scr(input [31:0] v);
    scr = {v[18:0], v[31:19]} ^ `FWCP_ACCESS_KEY;
  endfunction

  // Counts alive-bit changes over a fixed window
  task count_toggles(input int n);
    reg prev;
    tg = 0;
    prev = tx_status_q[15];
    repeat (n) begin
      @(negedge sys_clk);
      if (tx_status_q[15] !== prev) tg++;
      prev = tx_status_q[15];
    end
  endtask

  task end_sim;
    if (failures == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Hang guard, far above the length of the sequence below
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      end_sim();
    end
  end

  // ****
  // Test sequence
  // ****
  initial begin
    repeat (8) @(negedge sys_clk);
    rst_n = 1;
    `FWCP_CHK(station_addr_q, 9'h001)
    `FWCP_CHK({imm, cal, refused_q, qualified_q}, 14'h0000)
    cfg_station_addr = 9'h1FF;
    repeat (2) @(negedge sys_clk);
    `FWCP_CHK(station_addr_q, 9'h1FF)
    for (i = 0; i < 8; i++) begin
      fwcp_master_model_i.send(imm_c[i], 32'h0000_0000);
      `FWCP_CHK(imm, 8'h01 << i)
    end
    fwcp_master_model_i.frame(16'h0082, 32'h0000_0000);
    `FWCP_CHK(imm, 8'h00)
    fwcp_master_model_i.send(16'h0082, 32'h0000_0000);
    `FWCP_CHK(imm, 8'h80)
    for (i = 0; i < 5; i++) fwcp_master_model_i.send(wr_c[i], val[i]);
    `FWCP_CHK({preset_tare_q, setpoint1_q, setpoint2_q, setpoint3_q,
      sample_wt_q}, {val[0], val[1], val[2], val[3], val[4]})
    for (i = 0; i < 5; i++) begin
      fwcp_master_model_i.send(rd_c[i], 32'h0000_0000);
      `FWCP_CHK(tx_xchg_read_q, val[i])
    end
    fwcp_master_model_i.send(16'h0001, 32'h1234_5678);
    fwcp_master_model_i.send(16'h007D, 32'h1234_5678);
    `FWCP_CHK({tx_xchg_read_q, setpoint1_q, imm},
      {val[4], val[1], 8'h00})
    for (i = 0; i < 4; i++) begin
      fwcp_master_model_i.send(gate_c[i], 32'h0000_0000);
      `FWCP_CHK({cal, refused_q}, 5'h01)
    end
    fwcp_master_model_i.send(16'h007C, 32'hC0DE_0042);
    fwcp_master_model_i.send(16'h007B, 32'h0000_0000);
    `FWCP_CHK(tx_xchg_read_q, 32'hC0DE_0042)
    fwcp_master_model_i.send(16'h0078, 32'h0000_0000);
    fwcp_master_model_i.send(16'h007A, 32'h0000_0000);
    seed = tx_xchg_read_q;
    `FWCP_CHK(seed, scr(32'hC0DE_0042))
    fwcp_master_model_i.send(16'h007C, scr(seed));
    fwcp_master_model_i.send(16'h0079, 32'h0000_0000);
    `FWCP_CHK(qualified_q, 1'b1)
    fwcp_master_model_i.send(16'h007A, 32'h0000_0000);
    `FWCP_CHK(tx_xchg_read_q, 32'h0000_0000)
    for (i = 0; i < 4; i++) begin
      fwcp_master_model_i.send(gate_c[i], 32'h0000_0000);
      `FWCP_CHK({cal, refused_q}, {4'h1 << i, 1'b0})
    end
    remote_controlled_output_mode = 3'b010;
    local_outs = 3'b101;
    fwcp_master_model_i.drive(16'h0000);
    repeat (3) @(negedge sys_clk);
    `FWCP_CHK({out_close_q, tx_out_state_q},
      {3'b101, 16'h0005})
    fwcp_master_model_i.drive(16'h8002);
    repeat (3) @(negedge sys_clk);
    `FWCP_CHK({out_close_q, tx_out_state_q},
      {3'b010, 16'h0002})
    input_pins = 2'b10;
    gross_mag = 32'h000F_423F;
    net_mag = 32'h8000_0001;
    weigh_flags = 13'h1ABC;
    repeat (2) @(negedge sys_clk);
    `FWCP_CHK(tx_in_state_q, 16'h0002)
    `FWCP_CHK({tx_gross_q, tx_net_q},
      {32'h000F_423F, 32'h8000_0001})
    `FWCP_CHK(tx_status_q[14:0], 15'h1ABC)
    count_toggles(80);
    `FWCP_CHK(tg >= 3 && tg <= 4, 1'b1)
    core_healthy = 1'b0;
    repeat (2) @(negedge sys_clk);
    count_toggles(60);
    `FWCP_CHK(tg, 0)
    end_sim();
  end
endmodule

// ===== fwcp_defines.vh
`ifndef FWCP_DEFINES_VH
`define FWCP_DEFINES_VH

// ****
// Transmitted process image, byte offsets
// ****
`define FWCP_TX_LINK_CTL_OFS  16'h0000
`define FWCP_TX_IO_STATE_OFS  16'h0002
`define FWCP_TX_GROSS_OFS     16'h0004
`define FWCP_TX_NET_OFS       16'h0008
`define FWCP_TX_XCHG_RD_OFS   16'h000C
`define FWCP_TX_STATUS_OFS    16'h0010
`define FWCP_TX_IN_STATE_OFS  16'h0012
`define FWCP_TX_OUT_STATE_OFS 16'h0014

// ****
// Received process image, byte offsets
// ****
`define FWCP_RX_LINK_CTL_OFS  16'h0000
`define FWCP_RX_IO_CTL_OFS    16'h0002
`define FWCP_RX_CMD_OFS       16'h0004
`define FWCP_RX_OUT_DRV_OFS   16'h0006
`define FWCP_RX_XCHG_WR_OFS   16'h0008

// ****
// Station address
// ****
`define FWCP_ADDR_MIN         9'h001
`define FWCP_ADDR_MAX         9'h1FF
`define FWCP_ADDR_DEFAULT     9'h001

// ****
// Field positions
// ****
`define FWCP_DRV_FORCE_BIT    15
`define FWCP_ST_HEART_BIT     15
`define FWCP_ST_FLAG_W        13
`define FWCP_NUM_OUTS         3
`define FWCP_NUM_INS          2

// ****
// Command codes
// ****
`define FWCP_C_NONE           16'h0000
`define FWCP_C_TARE_ON        16'h0007
`define FWCP_C_ZERO           16'h0008
`define FWCP_C_TARE_OFF       16'h0009
`define FWCP_C_KEY_LOCK       16'h0015
`define FWCP_C_ALL_UNLOCK     16'h0016
`define FWCP_C_ALL_LOCK       16'h0017
`define FWCP_C_PTARE_RD       16'h0057
`define FWCP_C_PTARE_WR       16'h0058
`define FWCP_C_SP1_RD         16'h005A
`define FWCP_C_SP2_RD         16'h005B
`define FWCP_C_SP3_RD         16'h005C
`define FWCP_C_SP1_WR         16'h005D
`define FWCP_C_SP2_WR         16'h005E
`define FWCP_C_SP3_WR         16'h005F
`define FWCP_C_NVM_SAVE       16'h0063
`define FWCP_C_CAL_ZERO       16'h0064
`define FWCP_C_CAL_FIRST      16'h0065
`define FWCP_C_SAMPLE_RD      16'h0066
`define FWCP_C_SAMPLE_WR      16'h0067
`define FWCP_C_CAL_CANCEL     16'h0068
`define FWCP_C_CAL_ADD        16'h006A
`define FWCP_C_ID_SEND        16'h0078
`define FWCP_C_PW_SEND        16'h0079
`define FWCP_C_SEED_RD        16'h007A
`define FWCP_C_CRED_RD        16'h007B
`define FWCP_C_CRED_WR        16'h007C
`define FWCP_C_PTARE_EN       16'h0082

// ****
// Timing
// ****
`define FWCP_CLK_HZ           100000000
`define FWCP_HB_TIME_MS       1000
`define FWCP_HB_CYCLES        (`FWCP_HB_TIME_MS * (`FWCP_CLK_HZ / 1000))
`define FWCP_HB_CNT_W         27

// Arbitrary key for the access seed and password check
`define FWCP_ACCESS_KEY       32'h5A3C_96E1

`endif

// ===== fwcp_heartbeat.v
`timescale 1ns/10ps
`include "fwcp_defines.vh"

// ****
// Once-per-period tick divider
// ****
module fwcp_heartbeat #(
  parameter [`FWCP_HB_CNT_W-1:0] PERIOD = `FWCP_HB_CYCLES
) (
  input  wire sys_clk,  // System clock
  input  wire rst_n,    // Sync reset, active low
  input  wire run,      // Count while high
  output reg  tick      // One-cycle pulse per period
);

  reg [`FWCP_HB_CNT_W-1:0] cnt_q;

  // Counter holds while not running, so a stalled core stops the tick
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      cnt_q <= {`FWCP_HB_CNT_W{1'b0}};
      tick  <= 1'b0;
    end else if (run) begin
      if (cnt_q == PERIOD - 1'b1) begin
        cnt_q <= {`FWCP_HB_CNT_W{1'b0}};
        tick  <= 1'b1;
      end else begin
        cnt_q <= cnt_q + 1'b1;
        tick  <= 1'b0;
      end
    end else begin
      tick <= 1'b0;
    end
  end

endmodule

// ===== fwcp_master_model.sv
`timescale 1ns/10ps

// ****
// Ring master image source
// ****
module fwcp_master_model (
  input  wire        sys_clk,         // Clock
  output reg         rx_valid,        // Image strobe
  output reg  [15:0] rx_command_code, // Command word
  output reg  [15:0] rx_output_drive, // Drive word
  output reg  [31:0] rx_xchg_write    // Write exchange
);
  reg [15:0] last_q;

  // Link words are kept by the ring controller, never modelled
  initial begin
    rx_valid = 1'b0;
    rx_command_code = 16'h0000;
    rx_output_drive = 16'h0000;
    rx_xchg_write = 32'hA5A5_A5A5;
    last_q = 16'h0000;
  end

  // One image, value paired with its code; stale data inverted after
  task frame(input [15:0] code, input [31:0] value);
    @(negedge sys_clk);
    rx_valid = 1'b1;
    rx_command_code = code;
    rx_xchg_write = value;
    last_q = code;
    @(negedge sys_clk);
    rx_valid = 1'b0;
    rx_xchg_write = ~value;
  endtask

  // Equal commands need an idle code between them
  task send(input [15:0] code, input [31:0] value);
    if (code == last_q && code != 16'h0000) begin
      frame(16'h0000, ~value);
    end
    frame(code, value);
  endtask

  task drive(input [15:0] w);
    @(negedge sys_clk);
    rx_output_drive = w;
  endtask
endmodule
